//--- fmsu_pkg.sv
/*
 * Shared constants for the floating move/subtract unit: APB register map,
 * field positions, reset values, operation codes and sequencer states.
 * Assumes a 32-bit APB slave with byte addresses and one aligned word per register.
 */
package fmsu_pkg;

	localparam logic [7:0] FMSU_OFF_CMD = 8'h00;
	localparam logic [7:0] FMSU_OFF_EA = 8'h04;
	localparam logic [7:0] FMSU_OFF_IADDR = 8'h08;
	localparam logic [7:0] FMSU_OFF_CFG = 8'h0C;
	localparam logic [7:0] FMSU_OFF_PROT = 8'h10;
	localparam logic [7:0] FMSU_OFF_STAT = 8'h14;
	localparam logic [7:0] FMSU_OFF_FSEL = 8'h18;
	localparam logic [7:0] FMSU_OFF_FLO = 8'h1C;
	localparam logic [7:0] FMSU_OFF_FHI = 8'h20;

	localparam int FMSU_CMD_OP_LSB = 0;
	localparam int FMSU_CMD_REGF_BIT = 2;
	localparam int FMSU_CMD_R1_LSB = 3;
	localparam int FMSU_CMD_R2_LSB = 6;
	localparam int FMSU_CMD_GO_BIT = 31;

	localparam int FMSU_CFG_LIMIT_LSB = 0;
	localparam int FMSU_CFG_FPP_BIT = 16;
	localparam int FMSU_CFG_PROB_BIT = 17;
	localparam int FMSU_CFG_LVL_LSB = 18;
	localparam logic [31:0] FMSU_CFG_RST = 32'h0001_FFFF;
	localparam logic [31:0] FMSU_PROT_RST = 32'hFFFF_0000;
	localparam logic [4:0] FMSU_FSEL_RST = 5'h00;

	localparam int FMSU_ST_BUSY = 0;
	localparam int FMSU_ST_DONE = 1;
	localparam int FMSU_ST_OVF = 2;
	localparam int FMSU_ST_EVEN = 3;
	localparam int FMSU_ST_CARRY = 4;
	localparam int FMSU_ST_NEG = 5;
	localparam int FMSU_ST_ZERO = 6;
	localparam int FMSU_ST_ISA = 7;
	localparam int FMSU_ST_PROT = 8;
	localparam int FMSU_ST_SPEC = 9;
	localparam int FMSU_ST_IFUNC = 10;
	localparam int FMSU_ST_FPX = 11;

	localparam logic [1:0] FMSU_OP_MOVE = 2'h0;
	localparam logic [1:0] FMSU_OP_SUB = 2'h1;
	localparam logic [1:0] FMSU_OP_SUBD = 2'h2;

	localparam logic [16:0] FMSU_LEN_SINGLE = 17'h00003;
	localparam logic [16:0] FMSU_LEN_DOUBLE = 17'h00007;
	localparam logic [16:0] FMSU_IW_STORAGE = 17'h00003;
	localparam logic [16:0] FMSU_IW_REGISTER = 17'h00001;

	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_MEM, ST_EXEC, ST_DONE} fmsu_state_t;

endpackage

//--- fmsu_unit.sv
/*
 * Floating move-double and subtract (single and double) execution unit with
 * an APB register port, a per-level floating register set and a storage port.
 * Assumes storage answers mem_ack on the same clock and holds nothing itself.
 */
// Functional notes
// RULE1 - Move storage form writes all 64 register bits to storage; register unchanged.
// RULE2 - Move register form copies all 64 bits of first register into second.
// RULE3 - Issuer keeps bits 10, 11 and 13 zero in register move form.
// RULE4 - Move clears overflow, even, carry; sets negative and zero from moved value.
// RULE5 - Single storage subtract: high word minus storage word; low word kept.
// RULE6 - Single register subtract: second high word minus first; low word kept.
// RULE7 - Double storage subtract: register minus 64-bit storage operand into register.
// RULE8 - Double register subtract: second minus first, full 64 bits, into second.
// RULE9 - First register unchanged unless it is also the destination.
// RULE10 - Zero fraction result gets plus sign and zero characteristic.
// RULE11 - Overflow indicator set on overflow or underflow, else cleared.
// RULE12 - Even indicator set only on underflow, else cleared.
// RULE13 - Subtract clears carry; negative and zero follow the result.
// RULE14 - Instruction or operand beyond installed storage raises address check, terminates.
// RULE15 - Problem state access outside assigned area raises protect check.
// RULE16 - Odd effective address raises specification check and terminates.
// RULE17 - Missing floating option raises invalid-function trap; storage forms terminate.
// RULE18 - Register subtract forms are suppressed on invalid function; nothing altered.
// RULE19 - Arithmetic error in subtract raises floating-point exception trap.
// RULE20 - Register field selects from the set of the active interrupt level.
`timescale 1ns/1ps
module fmsu_unit
	import fmsu_pkg::*;
#(
	parameter int N_LEVELS = 4
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic mem_req, // Storage request
	output logic mem_we, // Storage write
	output logic mem_dbl, // Storage access is 64 bits
	output logic [15:0] mem_addr, // Storage byte address
	output logic [63:0] mem_wdata, // Storage write data
	input wire logic [63:0] mem_rdata, // Storage read data
	input wire logic mem_ack, // Storage answer
	output logic prog_check, // Program check pulse
	output logic soft_trap // Soft exception trap pulse
);

	fmsu_state_t state;
	logic [63:0] freg [0:N_LEVELS*8-1];
	logic [1:0] c_op;
	logic c_regf;
	logic [2:0] c_r1;
	logic [2:0] c_r2;
	logic [15:0] ea;
	logic [15:0] iaddr;
	logic [31:0] cfg;
	logic [31:0] prot;
	logic [4:0] fsel;
	logic [11:0] stat;
	logic [63:0] mem_buf;
	logic rf_we;
	logic [63:0] rf_wdata;
	logic [4:0] rf_widx;

	function automatic logic [4:0] fidx(input logic [1:0] lvl, input logic [2:0] r);
		fidx = {lvl, r}; // RULE20
	endfunction

	function automatic logic [65:0] fsub(input logic [63:0] a, input logic [63:0] b);
		logic [59:0] fa;
		logic [59:0] fb;
		logic [59:0] mag;
		logic [60:0] sum;
		logic sr;
		logic signed [9:0] ex;
		logic [6:0] d;
		fa = {a[55:0], 4'h0};
		fb = {b[55:0], 4'h0};
		sr = a[63];
		if (a[62:56] >= b[62:56]) begin
			ex = {3'b000, a[62:56]};
			d = a[62:56] - b[62:56];
			fb = (d > 7'd15) ? 60'h0 : fb >> {d, 2'b00};
		end else begin
			ex = {3'b000, b[62:56]};
			d = b[62:56] - a[62:56];
			fa = (d > 7'd15) ? 60'h0 : fa >> {d, 2'b00};
		end
		if (a[63] != b[63]) begin
			sum = {1'b0, fa} + {1'b0, fb};
		end else if (fa >= fb) begin
			sum = {1'b0, fa - fb};
		end else begin
			sum = {1'b0, fb - fa};
			sr = ~a[63];
		end
		if (sum[60]) begin
			sum = sum >> 4;
			ex = ex + 10'sd1;
		end
		mag = sum[59:0];
		for (int i = 0; i < 15; i++) begin
			if (mag[59:56] == 4'h0 && mag != 60'h0) begin
				mag = mag << 4;
				ex = ex - 10'sd1;
			end
		end
		if (mag == 60'h0) begin
			fsub = 66'h0; // RULE10
		end else begin
			fsub = {ex > 10'sd127, ex < 10'sd0, sr, ex[6:0], mag[59:4]};
		end
	endfunction

	wire logic [1:0] lvl = cfg[FMSU_CFG_LVL_LSB +: 2];
	wire logic [15:0] limit = cfg[FMSU_CFG_LIMIT_LSB +: 16];
	wire logic fp_present = cfg[FMSU_CFG_FPP_BIT];
	wire logic problem = cfg[FMSU_CFG_PROB_BIT];
	wire logic [63:0] src_val = freg[fidx(lvl, c_r1)];
	wire logic [63:0] dst_val = freg[fidx(lvl, c_r2)];
	wire logic is_dbl = (c_op != FMSU_OP_SUB);
	wire logic [16:0] ea_end = {1'b0, ea} + (is_dbl ? FMSU_LEN_DOUBLE : FMSU_LEN_SINGLE);
	wire logic [16:0] ia_end = {1'b0, iaddr} + (c_regf ? FMSU_IW_REGISTER : FMSU_IW_STORAGE);

	logic chk_isa;
	logic chk_prot;
	logic chk_spec;
	logic chk_ifunc;
	always_comb begin
		chk_isa = (ia_end > {1'b0, limit}) || (!c_regf && ea_end > {1'b0, limit}); // RULE14
		chk_prot = problem && ({1'b0, iaddr} < {1'b0, prot[15:0]} || ia_end > {1'b0, prot[31:16]} || // RULE15
			(!c_regf && ({1'b0, ea} < {1'b0, prot[15:0]} || ea_end > {1'b0, prot[31:16]})));
		chk_spec = !c_regf && ea[0]; // RULE16
		chk_ifunc = !fp_present || c_op == 2'h3; // RULE17
	end

	// Subtraction operands; single precision works on the high word only.
	logic [63:0] op_b;
	logic [65:0] sres;
	logic [63:0] sub_res;
	always_comb begin
		op_b = c_regf ? src_val : mem_buf;
		if (c_op == FMSU_OP_SUB) begin
			sres = fsub({dst_val[63:32], 32'h0}, {op_b[63:32], 32'h0});
			sub_res = {sres[63:32], dst_val[31:0]}; // RULE5 RULE6
		end else begin
			sres = fsub(dst_val, op_b); // RULE7 RULE8
			sub_res = sres[63:0];
		end
	end

	wire logic apb_wr = psel && penable && pwrite;
	wire logic busy = (state != ST_IDLE);
	wire logic go = apb_wr && paddr == FMSU_OFF_CMD && pwdata[FMSU_CMD_GO_BIT] && !busy;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (go) begin
						state <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (chk_isa || chk_prot || chk_spec || chk_ifunc) begin
						state <= ST_DONE; // RULE18
					end else if (c_regf) begin
						state <= ST_EXEC;
					end else begin
						state <= ST_MEM;
					end
				end
				ST_MEM: begin
					if (mem_ack) begin
						state <= (c_op == FMSU_OP_MOVE) ? ST_DONE : ST_EXEC;
					end
				end
				ST_EXEC: state <= ST_DONE;
				ST_DONE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Bits 10, 11 and 13 of the register move form have no field here and are never decoded.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_op <= FMSU_OP_MOVE;
			c_regf <= 1'b0;
			c_r1 <= 3'h0;
			c_r2 <= 3'h0;
			ea <= 16'h0000;
			iaddr <= 16'h0000;
			cfg <= FMSU_CFG_RST;
			prot <= FMSU_PROT_RST;
			fsel <= FMSU_FSEL_RST;
		end else if (apb_wr && !busy) begin
			case (paddr)
				FMSU_OFF_CMD: begin
					c_op <= pwdata[FMSU_CMD_OP_LSB +: 2];
					c_regf <= pwdata[FMSU_CMD_REGF_BIT];
					c_r1 <= pwdata[FMSU_CMD_R1_LSB +: 3];
					c_r2 <= pwdata[FMSU_CMD_R2_LSB +: 3];
				end
				FMSU_OFF_EA: ea <= pwdata[15:0];
				FMSU_OFF_IADDR: iaddr <= pwdata[15:0];
				FMSU_OFF_CFG: cfg <= {12'h000, pwdata[19:0]};
				FMSU_OFF_PROT: prot <= pwdata;
				FMSU_OFF_FSEL: fsel <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	// Storage port; request held until the storage answers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_dbl <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 64'h0;
			mem_buf <= 64'h0;
		end else if (state == ST_CHECK && !(chk_isa || chk_prot || chk_spec || chk_ifunc) && !c_regf) begin
			mem_req <= 1'b1;
			mem_we <= (c_op == FMSU_OP_MOVE);
			mem_dbl <= is_dbl;
			mem_addr <= ea;
			mem_wdata <= dst_val; // RULE1
		end else if (state == ST_MEM && mem_ack) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_buf <= mem_rdata;
		end
	end

	// Result write; only the destination register is touched.
	always_comb begin
		rf_we = 1'b0;
		rf_widx = fidx(lvl, c_r2); // RULE9
		rf_wdata = sub_res;
		if (state == ST_EXEC) begin
			rf_we = 1'b1;
			rf_wdata = (c_op == FMSU_OP_MOVE) ? src_val : sub_res; // RULE2
		end
	end

	always_ff @(posedge pclk) begin
		if (rf_we) begin
			freg[rf_widx] <= rf_wdata;
		end else if (apb_wr && !busy && paddr == FMSU_OFF_FLO) begin
			freg[fsel] <= {freg[fsel][63:32], pwdata};
		end else if (apb_wr && !busy && paddr == FMSU_OFF_FHI) begin
			freg[fsel] <= {pwdata, freg[fsel][31:0]};
		end
	end

	// Status: indicators and check flags; a new command clears the check flags.
	wire logic mv_done = (state == ST_MEM && mem_ack && c_op == FMSU_OP_MOVE) || (state == ST_EXEC && c_op == FMSU_OP_MOVE);
	wire logic [63:0] mv_val = c_regf ? src_val : dst_val;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= 12'h000;
		end else if (go) begin
			stat[FMSU_ST_DONE] <= 1'b0;
			stat[FMSU_ST_FPX:FMSU_ST_ISA] <= 5'h00;
		end else if (state == ST_CHECK) begin
			if (chk_isa) begin
				stat[FMSU_ST_ISA] <= 1'b1;
			end else if (chk_prot) begin
				stat[FMSU_ST_PROT] <= 1'b1;
			end else if (chk_spec) begin
				stat[FMSU_ST_SPEC] <= 1'b1;
			end else if (chk_ifunc) begin
				stat[FMSU_ST_IFUNC] <= 1'b1;
			end
		end else if (mv_done) begin
			stat[FMSU_ST_OVF] <= 1'b0; // RULE4
			stat[FMSU_ST_EVEN] <= 1'b0;
			stat[FMSU_ST_CARRY] <= 1'b0;
			stat[FMSU_ST_NEG] <= mv_val[63];
			stat[FMSU_ST_ZERO] <= (mv_val[55:0] == 56'h0);
		end else if (state == ST_EXEC) begin
			stat[FMSU_ST_OVF] <= sres[65] | sres[64]; // RULE11
			stat[FMSU_ST_EVEN] <= sres[64]; // RULE12
			stat[FMSU_ST_CARRY] <= 1'b0; // RULE13
			stat[FMSU_ST_NEG] <= sub_res[63];
			stat[FMSU_ST_ZERO] <= (sub_res[55:32] == 24'h0) && (c_op == FMSU_OP_SUB || sub_res[31:0] == 32'h0);
			stat[FMSU_ST_FPX] <= sres[65] | sres[64]; // RULE19
		end else if (state == ST_DONE) begin
			stat[FMSU_ST_DONE] <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_check <= 1'b0;
			soft_trap <= 1'b0;
		end else begin
			prog_check <= (state == ST_CHECK) && (chk_isa || chk_prot || chk_spec);
			soft_trap <= ((state == ST_CHECK) && chk_ifunc && !(chk_isa || chk_prot || chk_spec)) ||
				((state == ST_EXEC) && c_op != FMSU_OP_MOVE && (sres[65] | sres[64]));
		end
	end

	// APB read side; the slave always answers in the access phase.
	logic [31:0] next_prdata;
	always_comb begin
		pready = 1'b1;
		pslverr = 1'b0;
		next_prdata = 32'h0;
		case (paddr)
			FMSU_OFF_CMD: next_prdata = {23'h0, c_r2, c_r1, c_regf, c_op};
			FMSU_OFF_EA: next_prdata = {16'h0, ea};
			FMSU_OFF_IADDR: next_prdata = {16'h0, iaddr};
			FMSU_OFF_CFG: next_prdata = cfg;
			FMSU_OFF_PROT: next_prdata = prot;
			FMSU_OFF_STAT: next_prdata = {20'h0, stat[11:1], busy};
			FMSU_OFF_FSEL: next_prdata = {27'h0, fsel};
			FMSU_OFF_FLO: next_prdata = freg[fsel][31:0];
			FMSU_OFF_FHI: next_prdata = freg[fsel][63:32];
			default: pslverr = psel && penable;
		endcase
	end

	// Read data is captured at the setup edge so it stands from a flip-flop through the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end else begin
			prdata <= 32'h0;
		end
	end

	logic [63:0] past_src;
	always_ff @(posedge pclk) begin
		past_src <= src_val;
	end

	AST_MOVE_STORE: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		mem_req && mem_we |-> mem_wdata == dst_val && $stable(dst_val))
		else $error("store data differs from register");
	AST_MOVE_COPY: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		state == ST_EXEC && c_op == FMSU_OP_MOVE |-> rf_wdata == src_val && rf_widx == fidx(lvl, c_r2))
		else $error("register move copies wrong value");
	AST_MOVE_IND: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		mv_done |=> !stat[FMSU_ST_OVF] && !stat[FMSU_ST_EVEN] && !stat[FMSU_ST_CARRY])
		else $error("move left an indicator set");
	AST_LOW_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		rf_we && c_op == FMSU_OP_SUB |-> rf_wdata[31:0] == dst_val[31:0])
		else $error("single subtract altered low word");
	AST_SRC_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		state == ST_EXEC && c_regf && c_r1 != c_r2 |=> src_val == past_src)
		else $error("first register altered");
	AST_ZERO_PLUS: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		rf_we && c_op == FMSU_OP_SUBD && rf_wdata[55:0] == 56'h0 |-> rf_wdata[63:56] == 8'h00)
		else $error("zero result not forced plus");
	AST_EVEN_OVF: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		state == ST_DONE && stat[FMSU_ST_EVEN] |-> stat[FMSU_ST_OVF] && !stat[FMSU_ST_CARRY])
		else $error("even set without overflow");
	AST_ISA_TERM: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		state == ST_CHECK && chk_isa |=> state == ST_DONE && prog_check && stat[FMSU_ST_ISA] ##1 state == ST_IDLE)
		else $error("address check did not terminate");
	AST_SPEC: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		state == ST_CHECK && chk_spec && !chk_isa && !chk_prot |=> stat[FMSU_ST_SPEC] && !mem_req)
		else $error("odd address not checked");
	AST_SUPPRESS: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
		state == ST_CHECK && chk_ifunc && c_regf && !chk_isa && !chk_prot |=> !rf_we && soft_trap ##1 !rf_we)
		else $error("suppressed subtract wrote a register");
	AST_FPX: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
		state == ST_EXEC && c_op != FMSU_OP_MOVE && (sres[65] | sres[64]) |=> soft_trap && stat[FMSU_ST_FPX])
		else $error("arithmetic error not trapped");

	COV_STORE: cover property (@(posedge pclk) disable iff (!presetn) mem_req && mem_we && mem_ack);
	COV_SUBD_REG: cover property (@(posedge pclk) disable iff (!presetn) state == ST_EXEC && c_regf && c_op == FMSU_OP_SUBD);
	COV_SUB_MEM: cover property (@(posedge pclk) disable iff (!presetn) state == ST_MEM ##1 state == ST_EXEC);
	COV_UNDERFLOW: cover property (@(posedge pclk) disable iff (!presetn) state == ST_EXEC && sres[64]);

endmodule // fmsu_unit

//--- fmsu_mem_model.sv
/*
 * Storage partner for the floating move/subtract unit: a byte memory that
 * answers each request after a chosen number of wait cycles.
 * Assumes the unit holds its request unchanged until the cycle of mem_ack.
 */
`timescale 1ns/1ps
module fmsu_mem_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic [3:0] delay, // Wait cycles before the answer
	input wire logic mem_req, // Request
	input wire logic mem_we, // Store
	input wire logic mem_dbl, // 64-bit access
	input wire logic [15:0] mem_addr, // Byte address
	input wire logic [63:0] mem_wdata, // Store data
	output logic [63:0] mem_rdata, // Read data
	output logic mem_ack // Answer
);
	logic [7:0] mem [0:255];
	logic [3:0] cnt;
	logic [63:0] rd64;
	logic [63:0] last;

	assign mem_ack = mem_req && (cnt == delay);
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			rd64[63 - 8 * k -: 8] = mem[mem_addr[7:0] + 8'(k)];
		end
	end
	// Outside an answer the bus shows the inverse of the last value, so stale data never looks valid.
	assign mem_rdata = mem_ack ? (mem_dbl ? rd64 : {rd64[63:32], ~last[31:0]}) : ~last;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			last <= 64'h0;
		end else begin
			cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
			if (mem_ack) begin
				last <= mem_rdata;
				if (mem_we) begin
					for (int k = 0; k < (mem_dbl ? 8 : 4); k++) begin
						mem[mem_addr[7:0] + 8'(k)] <= mem_wdata[63 - 8 * k -: 8];
					end
				end
			end
		end
	end
endmodule // fmsu_mem_model

//--- fmsu_unit_test.sv
/*
 * Self-checking testbench for the floating move/subtract unit.
 * Assumes zero-wait APB answers and storage served by the partner model.
 */
`timescale 1ns/1ps
module fmsu_unit_test;
	import fmsu_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] delay = 4'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, ev, mem_req, mem_we, mem_dbl, mem_ack, prog_check, soft_trap;
	logic [15:0] mem_addr;
	logic [63:0] mem_wdata, mem_rdata;
	int fail_count = 0;
	int n_tests = 0;
	int npc = 0;
	int nst = 0;
	int cyc = 0;

	always #12.5 pclk = ~pclk;

	fmsu_unit fmsu_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_req(mem_req), .mem_we(mem_we), .mem_dbl(mem_dbl), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .prog_check(prog_check), .soft_trap(soft_trap));
	fmsu_mem_model fmsu_mem_model_i (.pclk(pclk), .presetn(presetn), .delay(delay), .mem_req(mem_req),
		.mem_we(mem_we), .mem_dbl(mem_dbl), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Counts the one-cycle check and trap pulses, and cuts a hang short.
	always @(posedge pclk) begin
		cyc++;
		if (prog_check === 1'b1) npc++;
		if (soft_trap === 1'b1) nst++;
		if (cyc == 6000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic setf(input logic [4:0] i, input logic [63:0] v);
		apb(1'b1, FMSU_OFF_FSEL, {27'h0, i});
		apb(1'b1, FMSU_OFF_FLO, v[31:0]);
		apb(1'b1, FMSU_OFF_FHI, v[63:32]);
	endtask

	task automatic chkf(input logic [4:0] i, input logic [63:0] e);
		logic [63:0] v;
		apb(1'b1, FMSU_OFF_FSEL, {27'h0, i});
		apb(1'b0, FMSU_OFF_FLO, 32'h0);
		v[31:0] = rv;
		apb(1'b0, FMSU_OFF_FHI, 32'h0);
		v[63:32] = rv;
		chk(v, e);
	endtask

	task automatic setm(input logic [7:0] a, input logic [63:0] v);
		for (int k = 0; k < 8; k++) fmsu_mem_model_i.mem[a + 8'(k)] = v[63 - 8 * k -: 8];
	endtask

	function automatic logic [63:0] getm(input logic [7:0] a);
		for (int k = 0; k < 8; k++) getm[63 - 8 * k -: 8] = fmsu_mem_model_i.mem[a + 8'(k)];
	endfunction

	// The expected flags e are STAT bits 11 down to 2; pulses follow from the check and trap bits.
	task automatic run(input logic [1:0] op, input logic rf, input logic [2:0] r1, input logic [2:0] r2,
		input logic [9:0] e);
		int k;
		int pc0;
		int st0;
		pc0 = npc;
		st0 = nst;
		k = 0;
		apb(1'b1, FMSU_OFF_CMD, {1'b1, 22'h0, r2, r1, rf, op});
		do begin
			apb(1'b0, FMSU_OFF_STAT, 32'h0);
			k++;
		end while (rv[0] !== 1'b0 && k < 50);
		chk(64'(rv[11:1]), 64'({e, 1'b1}));
		chk(64'(npc - pc0), 64'(e[7:5] != 3'h0));
		chk(64'(nst - st0), 64'(|e[9:8]));
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, FMSU_OFF_CFG, 32'h0);
		chk(rv, FMSU_CFG_RST);
		apb(1'b0, FMSU_OFF_PROT, 32'h0);
		chk(rv, FMSU_PROT_RST);
		apb(1'b1, FMSU_OFF_STAT, 32'hFFF);
		apb(1'b0, FMSU_OFF_STAT, 32'h0);
		chk(rv, 32'h0);
		apb(1'b0, 8'h24, 32'h0);
		chk({ev, rv}, 33'h1_0000_0000);
		setf(5'h01, 64'hFFF0_0000_0000_0000);
		setf(5'h02, 64'h7FF0_0000_0000_0000);
		run(2'h1, 1'b1, 3'h1, 3'h2, 10'h201);
		setf(5'h01, 64'h0010_0000_0000_0000);
		setf(5'h02, 64'h0011_0000_0000_0000);
		run(2'h1, 1'b1, 3'h1, 3'h2, 10'h203);
		apb(1'b1, FMSU_OFF_CFG, 32'h0005_FFFF);
		setf(5'h09, 64'hC130_0000_0000_0005);
		setf(5'h02, 64'h1111_1111_1111_1111);
		run(2'h0, 1'b1, 3'h1, 3'h2, 10'h008);
		chkf(5'h0A, 64'hC130_0000_0000_0005);
		chkf(5'h09, 64'hC130_0000_0000_0005);
		chkf(5'h02, 64'h1111_1111_1111_1111);
		apb(1'b1, FMSU_OFF_CFG, 32'h0001_FFFF);
		delay <= 4'h3;
		setf(5'h03, 64'h4112_3456_789A_BCDE);
		apb(1'b1, FMSU_OFF_EA, 32'h40);
		apb(1'b1, FMSU_OFF_IADDR, 32'h10);
		run(2'h0, 1'b0, 3'h0, 3'h3, 10'h000);
		chk(getm(8'h40), 64'h4112_3456_789A_BCDE);
		chkf(5'h03, 64'h4112_3456_789A_BCDE);
		setf(5'h04, 64'h4130_0000_AAAA_5555);
		setm(8'h48, 64'h4110_0000_DEAD_BEEF);
		apb(1'b1, FMSU_OFF_EA, 32'h48);
		run(2'h1, 1'b0, 3'h0, 3'h4, 10'h000);
		chkf(5'h04, 64'h4120_0000_AAAA_5555);
		chk(getm(8'h48), 64'h4110_0000_DEAD_BEEF);
		delay <= 4'h0;
		setf(5'h05, 64'h4130_0000_0000_0000);
		setm(8'h50, 64'h4110_0000_0000_0000);
		apb(1'b1, FMSU_OFF_EA, 32'h50);
		run(2'h2, 1'b0, 3'h0, 3'h5, 10'h000);
		chkf(5'h05, 64'h4120_0000_0000_0000);
		chk(getm(8'h50), 64'h4110_0000_0000_0000);
		setf(5'h01, 64'h4110_0000_0000_0000);
		setf(5'h02, 64'h4130_0000_1234_5678);
		run(2'h1, 1'b1, 3'h1, 3'h2, 10'h000);
		chkf(5'h02, 64'h4120_0000_1234_5678);
		chkf(5'h01, 64'h4110_0000_0000_0000);
		setf(5'h01, 64'h4130_0000_0000_0000);
		setf(5'h02, 64'h4110_0000_0000_0000);
		run(2'h2, 1'b1, 3'h1, 3'h2, 10'h008);
		chkf(5'h02, 64'hC120_0000_0000_0000);
		chkf(5'h01, 64'h4130_0000_0000_0000);
		setf(5'h03, 64'hC155_5555_5555_5555);
		run(2'h2, 1'b1, 3'h3, 3'h3, 10'h010);
		chkf(5'h03, 64'h0);
		apb(1'b1, FMSU_OFF_CFG, 32'h0001_00FF);
		apb(1'b1, FMSU_OFF_EA, 32'h100);
		run(2'h1, 1'b0, 3'h0, 3'h4, 10'h030);
		chkf(5'h04, 64'h4120_0000_AAAA_5555);
		apb(1'b1, FMSU_OFF_CFG, 32'h0003_FFFF);
		apb(1'b1, FMSU_OFF_PROT, 32'h0080_0040);
		apb(1'b1, FMSU_OFF_IADDR, 32'h50);
		apb(1'b1, FMSU_OFF_EA, 32'hA0);
		run(2'h1, 1'b0, 3'h0, 3'h4, 10'h050);
		apb(1'b1, FMSU_OFF_CFG, 32'h0001_FFFF);
		apb(1'b1, FMSU_OFF_EA, 32'h41);
		run(2'h1, 1'b0, 3'h0, 3'h4, 10'h090);
		apb(1'b1, FMSU_OFF_CFG, 32'h0000_FFFF);
		apb(1'b1, FMSU_OFF_EA, 32'h48);
		run(2'h2, 1'b0, 3'h0, 3'h4, 10'h110);
		chkf(5'h04, 64'h4120_0000_AAAA_5555);
		run(2'h2, 1'b1, 3'h1, 3'h2, 10'h110);
		chkf(5'h02, 64'hC120_0000_0000_0000);
		apb(1'b1, FMSU_OFF_CFG, 32'h0001_FFFF);
		run(2'h3, 1'b1, 3'h1, 3'h2, 10'h110);
		chkf(5'h02, 64'hC120_0000_0000_0000);
		tally_and_finish();
	end
endmodule // fmsu_unit_test
